/* File: hw/rtc_ctrl_params.svh */
// offsets, field positions, reset values and timing counts of the rtc
// control block; included by the package, whose macros the design module uses
`ifndef RTC_CTRL_PARAMS_SVH
`define RTC_CTRL_PARAMS_SVH

// register addresses on the byte-wide bus
`define ADDR_RATE_OSC 7'h0a
`define ADDR_MODE_EN 7'h0b
`define ADDR_INT_FLAGS 7'h0c
`define ADDR_BACKUP 7'h0d

// rate_and_oscillator_control fields
`define RA_UIP_BIT 7
`define RA_DV_HI 6
`define RA_DV_LO 4
`define RA_RS_HI 3
`define RA_RS_LO 0
`define DV_RUN 3'h2

// mode_and_enable_control fields
`define RB_SET_BIT 7
`define RB_PIE_BIT 6
`define RB_AIE_BIT 5
`define RB_UIE_BIT 4
`define RB_SQUARE_WAVE_ENABLE_BIT 3
`define RB_DM_BIT 2
`define RB_H24_BIT 1
`define RB_DSE_BIT 0

// interrupt_flags and backup_status fields
`define RC_COMBINED_REQUEST_FLAG_BIT 7
`define RC_PF_BIT 6
`define RC_AF_BIT 5
`define RC_UF_BIT 4
`define RD_VRT_BIT 7

// power-on values of the bits that the reset pin leaves alone
`define POR_RATE_OSC 7'h00
`define POR_MODE 4'h0

// timebase and divider
`define TIMEBASE_HZ 32768
`define DIV_STAGES 15
`define UIP_LEAD_NS 244000
`define UIP_LEAD_TICKS \
  ((64'd244000 * 64'd32768 + 64'd999999999) / 64'd1000000000)
`define FIRST_UPDATE_MS 500
`define FIRST_UPDATE_TICKS ((`FIRST_UPDATE_MS * `TIMEBASE_HZ) / 1000)

// alarm wildcard marker in the top two bits
`define ALARM_ANY 2'h3

`endif

/* File: hw/rtc_ctrl_pkg.sv */
// types shared by the rtc control block
// assumes rtc_ctrl_params.svh is on the include path
package rtc_ctrl_pkg;
  `include "rtc_ctrl_params.svh"

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    OSC_OFF,
    OSC_HOLD,
    OSC_RUN
  } osc_mode_e;
endpackage : rtc_ctrl_pkg

/* File: hw/rtc_ctrl.sv */
// rtc control, status and interrupt block: four control registers,
// divider chain, periodic/alarm/update flags and square wave.
// assumes a byte bus with separate address and data lines and a 32.768 khz timebase on pins,
// and time/alarm bytes from the counting logic on sys_clk.
//
// Functional notes
// - uip low guarantees no transfer for at least 244 us
// - uip read-only, reset-proof; set bit blocks transfers, forces uip 0
// - chain runs only with 010; 11x holds chain reset, osc on
// - first update 500 ms after run pattern written
// - rate select picks one of 13 taps or none, shared
// - rate select readable, writable, kept through reset
// - set bit freezes user copy; untouched by reset
// - periodic enable gates pf; pf still sets; reset clears enable
// - alarm fires each matching second; 11xxxxxx matches anything
// - update enable cleared by reset or set bit rising
// - square wave follows tap when enabled, else low
// - binary and 24-hour bits kept through reset
// - dst: first april sunday 1:59:59 jumps to 3:00:00
// - dst: last october sunday first 1:59:59 goes to 1:00:00
// - sunday conditions checked at midnight with dst enable set
// - combined flag when any flag and enable; irq low meanwhile
// - flag register read clears all flags; reset clears too
// - pf read-only, set on each falling edge of the selected tap
// - update-done flag set at end of each update
// - unused flag and backup bits read 0, ignore writes
// - backup valid flag read-only, reset-proof, 1 when supply good
// - enabling with flag already set asserts irq at once
// - flags snapshotted on read; new events kept, not lost
`timescale 1ns/10ps

module rtc_ctrl
  import rtc_ctrl_pkg::*;
#(
  parameter int DIV_W = `DIV_STAGES
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por,
  // pins
  input wire logic osc_in,
  input wire logic backup_supply_ok,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [6:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_oe,
  output logic irq_n,
  output logic square_wave_out,
  // time and alarm bytes from counting logic
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_dow,
  input wire logic [7:0] cur_date,
  input wire logic [7:0] cur_month,
  input wire logic [7:0] alm_sec,
  input wire logic [7:0] alm_min,
  input wire logic [7:0] alm_hour,
  // to counting logic
  output logic update_xfer,
  output logic dst_spring_fwd,
  output logic dst_fall_back,
  output logic binary_format_select,
  output logic hour24_select
);

  // pin synchronisers
  logic [1:0] osc_s_q, bvalid_s_q, cs_s_q, rd_s_q, wr_s_q;
  logic [6:0] addr_s1_q, addr_s2_q;
  logic [7:0] wdata_s1_q, wdata_s2_q;
  logic osc_d_q, rd_d_q, wr_d_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_s_q <= 2'h0;
      bvalid_s_q <= 2'h0;
      cs_s_q <= 2'h0;
      rd_s_q <= 2'h0;
      wr_s_q <= 2'h0;
      addr_s1_q <= 7'h00;
      addr_s2_q <= 7'h00;
      wdata_s1_q <= 8'h00;
      wdata_s2_q <= 8'h00;
      osc_d_q <= 1'b0;
      rd_d_q <= 1'b0;
      wr_d_q <= 1'b0;
    end else begin
      osc_s_q <= {osc_s_q[0], osc_in};
      bvalid_s_q <= {bvalid_s_q[0], backup_supply_ok};
      cs_s_q <= {cs_s_q[0], ~bus_cs_n};
      rd_s_q <= {rd_s_q[0], ~bus_rd_n};
      wr_s_q <= {wr_s_q[0], ~bus_wr_n};
      addr_s1_q <= bus_addr;
      addr_s2_q <= addr_s1_q;
      wdata_s1_q <= bus_wdata;
      wdata_s2_q <= wdata_s1_q;
      osc_d_q <= osc_s_q[1];
      rd_d_q <= rd_s_q[1] & cs_s_q[1];
      wr_d_q <= wr_s_q[1] & cs_s_q[1];
    end
  end

  logic rd_act, rd_start, wr_act, wr_end;
  assign rd_act = rd_s_q[1] & cs_s_q[1];
  assign rd_start = rd_act & ~rd_d_q;
  assign wr_act = wr_s_q[1] & cs_s_q[1];
  // write taken at strobe end so data has settled
  assign wr_end = wr_d_q & ~wr_act;

  logic wr_a, wr_b, rd_c;
  assign wr_a = wr_end && (addr_s2_q == `ADDR_RATE_OSC);
  assign wr_b = wr_end && (addr_s2_q == `ADDR_MODE_EN);
  assign rd_c = rd_start && (addr_s2_q == `ADDR_INT_FLAGS);

  // registers that only power-on sets up
  logic [2:0] dv_q;
  logic [3:0] rs_q;
  logic set_q, dm_q, h24_q, dse_q;

  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      {dv_q, rs_q} <= `POR_RATE_OSC;
    end else if (wr_a) begin
      dv_q <= wdata_s2_q[`RA_DV_HI:`RA_DV_LO];
      rs_q <= wdata_s2_q[`RA_RS_HI:`RA_RS_LO];
    end
  end

  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      {set_q, dm_q, h24_q, dse_q} <= `POR_MODE;
    end else if (wr_b) begin
      set_q <= wdata_s2_q[`RB_SET_BIT];
      dm_q <= wdata_s2_q[`RB_DM_BIT];
      h24_q <= wdata_s2_q[`RB_H24_BIT];
      dse_q <= wdata_s2_q[`RB_DSE_BIT];
    end
  end

  // enables cleared by the reset pin
  logic pie_q, aie_q, uie_q, square_wave_enable_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pie_q <= 1'b0;
      aie_q <= 1'b0;
      uie_q <= 1'b0;
      square_wave_enable_q <= 1'b0;
    end else if (wr_b) begin
      pie_q <= wdata_s2_q[`RB_PIE_BIT];
      aie_q <= wdata_s2_q[`RB_AIE_BIT];
      square_wave_enable_q <= wdata_s2_q[`RB_SQUARE_WAVE_ENABLE_BIT];
      // set bit going high wins over the written enable
      uie_q <= wdata_s2_q[`RB_UIE_BIT] &
               ~(wdata_s2_q[`RB_SET_BIT] & ~set_q);
    end
  end

  // oscillator mode
  osc_mode_e osc_mode;
  always_comb begin
    if (dv_q == `DV_RUN) begin
      osc_mode = OSC_RUN;
    end else if (dv_q[2:1] == 2'h3) begin
      osc_mode = OSC_HOLD;
    end else begin
      osc_mode = OSC_OFF;
    end
  end

  logic tick;
  assign tick = (osc_mode != OSC_OFF) && osc_s_q[1] && !osc_d_q;

  // single binary divider on the timebase
  localparam logic [DIV_W-1:0] DIV_START =
    DIV_W'((1 << DIV_W) - `FIRST_UPDATE_TICKS);
  localparam logic [DIV_W-1:0] UIP_FROM =
    DIV_W'((1 << DIV_W) - 32'(`UIP_LEAD_TICKS) - 1);
  logic [DIV_W-1:0] div_q;
  logic run_load, wrap;
  assign run_load = wr_a && (wdata_s2_q[`RA_DV_HI:`RA_DV_LO] == `DV_RUN)
                    && (dv_q != `DV_RUN);
  assign wrap = tick && (osc_mode == OSC_RUN) && (&div_q);

  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      div_q <= '0;
    end else if (run_load) begin
      div_q <= DIV_START;
    end else if (osc_mode == OSC_HOLD) begin
      div_q <= '0;
    end else if (tick && osc_mode == OSC_RUN) begin
      div_q <= div_q + 1'b1;
    end
  end

  // update pending window ahead of the transfer
  logic uip_q, xfer;
  assign xfer = wrap && !set_q;

  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      uip_q <= 1'b0;
    end else if (set_q || osc_mode != OSC_RUN) begin
      uip_q <= 1'b0;
    end else if (wrap) begin
      uip_q <= 1'b0;
    end else if (div_q >= UIP_FROM) begin
      uip_q <= 1'b1;
    end
  end

  // tap selection
  logic [3:0] tap_idx;
  logic tap_en;
  always_comb begin
    tap_en = (rs_q != 4'h0);
    tap_idx = 4'h0;
    if (rs_q == 4'h1 || rs_q == 4'h2) begin
      tap_idx = rs_q + 4'h5;
    end else if (rs_q >= 4'h3) begin
      tap_idx = rs_q - 4'h2;
    end
  end

  logic tap, tap_d_q, pf_ev;
  assign tap = tap_en && div_q[tap_idx];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tap_d_q <= 1'b0;
    end else begin
      tap_d_q <= tap;
    end
  end
  assign pf_ev = tap_d_q && !tap;

  // alarm compare with wildcard bytes
  logic [2:0] alm_hit;
  logic [7:0] alm_b [3];
  logic [7:0] cur_b [3];
  assign alm_b[0] = alm_sec;
  assign alm_b[1] = alm_min;
  assign alm_b[2] = alm_hour;
  assign cur_b[0] = cur_sec;
  assign cur_b[1] = cur_min;
  assign cur_b[2] = cur_hour;

  for (genvar i = 0; i < 3; i++) begin : g_alm
    assign alm_hit[i] = (alm_b[i][7:6] == `ALARM_ANY) ||
                        (alm_b[i] == cur_b[i]);
  end

  logic af_ev, uf_ev;
  assign af_ev = xfer && (&alm_hit);
  assign uf_ev = xfer;

  // daylight saving decision
  logic is_mid, is_0159, is_sun, apr_wk1, oct_last;
  logic [7:0] v59, v10, v25;
  assign v59 = dm_q ? 8'h3b : 8'h59;
  assign v10 = dm_q ? 8'h0a : 8'h10;
  assign v25 = dm_q ? 8'h19 : 8'h25;
  assign is_mid = (cur_sec == 8'h00) && (cur_min == 8'h00) &&
                  (h24_q ? (cur_hour == 8'h00) :
                   (cur_hour == (dm_q ? 8'h0c : 8'h12)));
  assign is_0159 = (cur_sec == v59) && (cur_min == v59) &&
                   (cur_hour == 8'h01);
  assign is_sun = (cur_dow == 8'h01);
  assign apr_wk1 = is_sun && (cur_month == 8'h04) && (cur_date <= 8'h07);
  assign oct_last = is_sun && (cur_month == v10) && (cur_date >= v25);

  logic spring_day_q, fall_day_q, fall_done_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spring_day_q <= 1'b0;
      fall_day_q <= 1'b0;
      fall_done_q <= 1'b0;
    end else if (xfer && is_mid) begin
      spring_day_q <= dse_q && apr_wk1;
      fall_day_q <= dse_q && oct_last;
      fall_done_q <= 1'b0;
    end else if (xfer && fall_day_q && is_0159) begin
      fall_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      update_xfer <= 1'b0;
      dst_spring_fwd <= 1'b0;
      dst_fall_back <= 1'b0;
    end else begin
      update_xfer <= xfer;
      dst_spring_fwd <= xfer && dse_q && spring_day_q && is_0159;
      dst_fall_back <= xfer && dse_q && fall_day_q && !fall_done_q &&
                       is_0159;
    end
  end

  // flags: read takes a snapshot and clears, new events still land
  logic pf_q, af_q, uf_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pf_q <= 1'b0;
      af_q <= 1'b0;
      uf_q <= 1'b0;
    end else if (rd_c) begin
      pf_q <= pf_ev;
      af_q <= af_ev;
      uf_q <= uf_ev;
    end else begin
      pf_q <= pf_q | pf_ev;
      af_q <= af_q | af_ev;
      uf_q <= uf_q | uf_ev;
    end
  end

  logic combined_request_flag;
  assign combined_request_flag = (pf_q & pie_q) | (af_q & aie_q) | (uf_q & uie_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~combined_request_flag;
    end
  end

  // read data
  byte_t rd_val;
  logic hit;
  always_comb begin
    rd_val = 8'h00;
    hit = 1'b1;
    case (addr_s2_q)
      `ADDR_RATE_OSC: rd_val = {uip_q, dv_q, rs_q};
      `ADDR_MODE_EN:
        rd_val = {set_q, pie_q, aie_q, uie_q, square_wave_enable_q, dm_q, h24_q, dse_q};
      `ADDR_INT_FLAGS: rd_val = {combined_request_flag, pf_q, af_q, uf_q, 4'h0};
      `ADDR_BACKUP: rd_val[`RD_VRT_BIT] = bvalid_s_q[1];
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
      bus_rdata_oe <= 1'b0;
    end else begin
      if (rd_start) begin
        bus_rdata <= rd_val;
      end
      bus_rdata_oe <= rd_act && hit;
    end
  end

  // square wave output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      square_wave_out <= 1'b0;
    end else begin
      square_wave_out <= square_wave_enable_q && tap;
    end
  end

  // mode copies follow power-on only, the reset pin leaves them alone
  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      binary_format_select <= 1'b0;
      hour24_select <= 1'b0;
    end else begin
      binary_format_select <= dm_q;
      hour24_select <= h24_q;
    end
  end

endmodule : rtc_ctrl

/* File: bench/rtc_host_model.sv */
// host processor model for the rtc control block byte bus
// assumes the bench calls xfer on a falling edge of sys_clk
`timescale 1ns/10ps

module rtc_host_model (
  // clock
  input wire logic sys_clk,
  // bus pins
  output logic bus_cs_n,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic [6:0] bus_addr,
  output logic [7:0] bus_wdata
);
  initial begin
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_addr = 7'h7f;
    bus_wdata = 8'h00;
  end

  // setup 3, strobe 6, gap 8 clocks for the 2-flop input sync
  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    repeat (3) @(negedge sys_clk);
    bus_cs_n = 1'b0;
    bus_rd_n = wr;
    bus_wr_n = !wr;
    repeat (6) @(negedge sys_clk);
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // released lines show garbage, not the last value
    bus_addr = ~a;
    bus_wdata = ~d;
    repeat (4) @(negedge sys_clk);
  endtask : xfer
endmodule : rtc_host_model

/* File: bench/rtc_ctrl_chk.sv */
// port checker for rtc_ctrl, bound to every instance
// assumes one clock domain on sys_clk
`timescale 1ns/10ps

module rtc_ctrl_chk (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por,
  // bus
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [6:0] bus_addr,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rdata_oe,
  // outputs
  input wire logic irq_n,
  input wire logic square_wave_out,
  input wire logic update_xfer,
  input wire logic binary_format_select,
  input wire logic hour24_select
);
  logic [3:0] wr_age_q;

  // clocks since the last write strobe on the pins
  always_ff @(posedge sys_clk or posedge por) begin
    if (por) wr_age_q <= 4'hf;
    else if (!bus_cs_n && !bus_wr_n) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RST_QUIET: assert property (disable iff (por) rst |-> irq_n &&
    !square_wave_out && !bus_rdata_oe && !update_xfer)
    else $error("outputs active during reset");
  AST_XFER_PULSE: assert property (update_xfer |=> !update_xfer [*8])
    else $error("transfer pulse repeated");
  AST_OE_CAUSE: assert property ($rose(bus_rdata_oe) |->
    $past(!bus_cs_n && !bus_rd_n, 2) && bus_addr inside {[7'h0a:7'h0d]})
    else $error("read answer without a mapped read");
  AST_OE_DROP: assert property ($rose(bus_cs_n) |-> ##[1:4] !bus_rdata_oe)
    else $error("read enable held after release");
  AST_C_LOW_ZERO: assert property (bus_rdata_oe && bus_addr == 7'h0c
    |-> bus_rdata[3:0] == 4'h0) else $error("flag low bits not zero");
  AST_D_ZERO: assert property (bus_rdata_oe && bus_addr == 7'h0d
    |-> bus_rdata[6:0] == 7'h00) else $error("backup low bits not zero");
  AST_COMBINED_REQUEST_FLAG_PIN: assert property ($rose(bus_rdata_oe) && bus_addr == 7'h0c
    && bus_rdata[7] |-> !irq_n || !$past(irq_n) || !$past(irq_n, 2))
    else $error("request flag read without irq low");
  AST_RDATA_STABLE: assert property (bus_rdata_oe && $past(bus_rdata_oe)
    |-> $stable(bus_rdata)) else $error("read data moved during read");
  AST_FMT_WRITE: assert property (disable iff (por)
    $changed(binary_format_select) |-> wr_age_q <= 4'd8)
    else $error("format bit changed without a write");
  AST_H24_WRITE: assert property (disable iff (por)
    $changed(hour24_select) |-> wr_age_q <= 4'd8)
    else $error("hour mode changed without a write");

  cover property (update_xfer);
  cover property ($fell(irq_n));
  cover property ($rose(square_wave_out));
endmodule : rtc_ctrl_chk

bind rtc_ctrl rtc_ctrl_chk chk_u (.*);

/* File: bench/rtc_ctrl_bench.sv */
// self-checking bench for rtc_ctrl with a host bus model
// assumes osc_in is sped up to one tick per 4 clocks
`timescale 1ns/10ps

module rtc_ctrl_bench;
  import rtc_ctrl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic osc_in = 1'b0;
  logic backup_supply_ok = 1'b1;
  logic bus_cs_n, bus_rd_n, bus_wr_n, bus_rdata_oe, irq_n;
  logic square_wave_out, update_xfer;
  logic [6:0] bus_addr;
  byte_t bus_wdata, bus_rdata, b;
  byte_t cur_b[6] = '{default: 8'h00};
  byte_t alm_b[3] = '{default: 8'hc0};
  logic [15:0] q[$];
  logic [15:0] note;
  logic oe_seen = 1'b0;
  logic [3:0] rs;
  int errors = 0, n_compared = 0, cyc = 0, sqw_rises = 0, t_run = 0;

  always #12.5 sys_clk = ~sys_clk;
  always #50 osc_in = ~osc_in;
  always @(posedge square_wave_out) sqw_rises++;

  rtc_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .por(por),
    .osc_in(osc_in), .backup_supply_ok(backup_supply_ok),
    .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .irq_n(irq_n),
    .square_wave_out(square_wave_out), .cur_sec(cur_b[0]),
    .cur_min(cur_b[1]), .cur_hour(cur_b[2]), .cur_dow(cur_b[3]),
    .cur_date(cur_b[4]), .cur_month(cur_b[5]), .alm_sec(alm_b[0]),
    .alm_min(alm_b[1]), .alm_hour(alm_b[2]), .update_xfer(update_xfer),
    .dst_spring_fwd(), .dst_fall_back(), .binary_format_select(),
    .hour24_select());

  rtc_host_model host_u (.sys_clk(sys_clk), .bus_cs_n(bus_cs_n),
    .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata));

  task automatic chk(input byte_t got, input byte_t exp, input byte_t m);
    n_compared++;
    if ((got & m) !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [6:0] a, input byte_t e, input byte_t m = 8'hff);
    q.push_back({m, e});
    host_u.xfer(1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [6:0] a, input byte_t d);
    host_u.xfer(1'b1, a, d);
  endtask : wr

  task automatic pulse_rst;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : pulse_rst

  task automatic complete_run;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  // answer watcher: first cycle of each read answer
  always @(negedge sys_clk) begin
    cyc++;
    if (bus_rdata_oe === 1'b1 && !oe_seen) begin
      if (q.size() == 0) begin
        errors++;
        $display("ERROR %0t unexpected read answer", $time);
      end else begin
        note = q.pop_front();
        chk(bus_rdata, note[7:0], note[15:8]);
      end
    end
    oe_seen = (bus_rdata_oe === 1'b1);
    if (cyc > 90000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    void'($urandom(18054));
    foreach (cur_b[i]) cur_b[i] = 8'($urandom);
    foreach (alm_b[i]) alm_b[i] = 8'hc0 | 8'($urandom);
    rs = 4'($urandom_range(15, 1));
    b = 8'($urandom) & 8'h0e;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    por = 1'b0;
    repeat (3) @(negedge sys_clk);
    rd(7'h0d, 8'h80);
    wr(7'h0d, 8'hff);
    wr(7'h0c, 8'hff);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h7f);
    rd(7'h0d, 8'h80);
    rd(7'h0c, 8'h00);
    host_u.xfer(1'b0, 7'h30, 8'h00);
    backup_supply_ok = 1'b0;
    rd(7'h0d, 8'h00);
    backup_supply_ok = 1'b1;
    wr(7'h0a, {4'he, rs});
    wr(7'h0b, b);
    rd(7'h0b, b);
    pulse_rst();
    rd(7'h0b, b & 8'h06);
    rd(7'h0a, {4'h6, rs});
    wr(7'h0a, 8'h23);
    t_run = cyc;
    repeat (40) @(negedge sys_clk);
    rd(7'h0c, 8'h40);
    wr(7'h0b, 8'h40);
    chk({7'h00, irq_n}, 8'h00, 8'hff);
    rd(7'h0c, 8'hc0);
    wr(7'h0a, 8'h20);
    rd(7'h0c, 8'h00, 8'h00);
    repeat (40) @(negedge sys_clk);
    rd(7'h0c, 8'h00);
    chk({7'h00, irq_n}, 8'h01, 8'hff);
    wr(7'h0b, 8'h1c);
    wr(7'h0a, 8'h23);
    while (update_xfer !== 1'b1) @(negedge sys_clk);
    chk(8'((cyc - t_run) inside {[65516:65556]}), 8'h01, 8'hff);
    chk(8'(sqw_rises > 8), 8'h01, 8'hff);
    repeat (4) @(negedge sys_clk);
    chk({7'h00, irq_n}, 8'h00, 8'hff);
    rd(7'h0c, 8'hb0, 8'hb0);
    wr(7'h0b, 8'h9c);
    rd(7'h0b, 8'h8c);
    rd(7'h0a, 8'h00, 8'h80);
    complete_run();
  end
endmodule : rtc_ctrl_bench
